// >>> hdl/pixel_array_readout_addressing.sv
`include "readout_consts.svh"
`default_nettype none

// Notes on behaviour
// - Array is 364 columns by 296 rows
// - Window sizes: NTSC, PAL/CIF, QCIF
// - Fixed window corners land on green one; pan/tilt corner as programmed
// - NTSC window offset slightly from centre
// - Fixed-corner QCIF window centred in the array
// - Reset gives raster scan, horizontal shuffle on
// - Shuffle: one column parity, then the other
// - Counters run from start to size limit
// - PAL/CIF skip four columns, two rows border
// - Fixed starts except pan/tilt QCIF
// - Pan/tilt starts: columns 1-185, rows 5-149
// - Out-of-range pan/tilt starts clipped automatically
// - Black rows below 5, dark above
// - Pan/tilt may read the border columns
// - Control A bit 7 enables horizontal shuffle
// - Control B bit 3 enables mirror
// - Control B bit 2 enables vertical shuffle
// - Control B bit 4 enables vertical flip
// - Mirror reverses column order within row
// - Vertical shuffle: rows at odd window offsets, then even
// - All four options combine freely
// - Flip reverses row order in window
// - Pan/tilt starts held in registers 88-91
module pixel_array_readout_addressing
  import readout_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  // Video timing control
  input  wire readout_pkg::video_mode_t video_mode,
  input  wire logic                     frame_start,
  input  wire logic                     pix_adv,
  // Serial register access
  input  wire logic                     reg_wr_en,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  // Pixel address stream
  output logic      [8:0]               col_addr,
  output logic      [8:0]               row_addr,
  output logic                          pix_valid,
  output logic                          line_last,
  output logic                          frame_last,
  output logic                          frame_busy
);

  import readout_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    scan_state_t st;        // Sequencer state
    window_t     win;       // Window latched at frame start
    logic        hshuf;     // Horizontal shuffle for this frame
    logic        hmir;      // Horizontal mirror for this frame
    logic        vshuf;     // Vertical shuffle for this frame
    logic        vflip;     // Vertical flip for this frame
    logic [8:0]  col;       // Output column address
    logic [8:0]  row;       // Output row address
    logic        valid;     // Output address valid
    logic        lline;     // Last pixel of a line
    logic        lframe;    // Last pixel of the frame
    logic [7:0]  rdata;     // Registered read data
  } top_state_t;

  top_state_t s_r;          // Registered state
  top_state_t s_nxt;        // Next state

  // Register file outputs
  logic [7:0] ctrl_a;       // Readout format control A
  logic [7:0] ctrl_b;       // Readout format control B
  logic [8:0] x_offset;     // Programmed column start
  logic [8:0] y_offset;     // Programmed row start
  logic [7:0] rdata_comb;   // Read mux result

  // Axis sequencer handshakes
  logic       ax_load;      // Restart both axes
  logic       col_step;     // Advance column
  logic       row_step;     // Advance row
  logic [8:0] col_now;      // Column under the counter
  logic [8:0] row_now;      // Row under the counter
  logic       col_last;     // Column counter at end of line
  logic       row_last;     // Row counter at end of window

  window_t    win_sel;      // Window for the selected mode

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Saturate a value into an inclusive range
  function automatic logic [8:0] clamp9(input logic [8:0] v,
                                        input logic [8:0] lo,
                                        input logic [8:0] hi);
    if (v < lo) begin
      clamp9 = lo;
    end else if (v > hi) begin
      clamp9 = hi;
    end else begin
      clamp9 = v;
    end
  endfunction : clamp9

  // Window placement per video mode
  function automatic window_t mode_window(input video_mode_t m,
                                          input logic [8:0]  xu,
                                          input logic [8:0]  yu);
    window_t r;
    r = '{x0: `PAL_X0, y0: `PAL_Y0, w: `PAL_W, h: `PAL_H};
    unique case (m)
      MODE_NTSC: begin
        // Off-centre so the corner stays green one
        r = '{x0: `NTSC_X0, y0: `NTSC_Y0,
              w: `NTSC_W, h: `NTSC_H};
      end
      MODE_PAL, MODE_CIF: begin
        // Border of four columns and two rows left unread
        r = '{x0: `PAL_X0, y0: `PAL_Y0,
              w: `PAL_W, h: `PAL_H};
      end
      MODE_SS_QCIF: begin
        // Centred, fixed corner
        r = '{x0: `QCIF_X0, y0: `QCIF_Y0,
              w: `QCIF_W, h: `QCIF_H};
      end
      MODE_PT_QCIF: begin
        // User corner, clipped; outer border columns reachable
        r = '{x0: clamp9(xu, `PT_X_MIN, `PT_X_MAX),
              y0: clamp9(yu, `PT_Y_MIN, `PT_Y_MAX),
              w: `QCIF_W, h: `QCIF_H};
      end
      default: begin
        // Unused mode codes fall back to CIF placement
        r = '{x0: `PAL_X0, y0: `PAL_Y0, w: `PAL_W, h: `PAL_H};
      end
    endcase
    mode_window = r;
  endfunction : mode_window

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  control_regs u_regs (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clk_en   (clk_en),
    .wr_en    (reg_wr_en),
    .addr     (reg_addr),
    .wdata    (reg_wdata),
    .rdata    (rdata_comb),
    .ctrl_a   (ctrl_a),
    .ctrl_b   (ctrl_b),
    .x_offset (x_offset),
    .y_offset (y_offset)
  );

  // ----------------------------------------------------------------------
  // Column and row counters
  // ----------------------------------------------------------------------

  // Column counter: shuffle and mirror
  axis_sequencer #(
    .W (9)
  ) u_col (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clk_en  (clk_en),
    .load    (ax_load),
    .step    (col_step),
    .start   (s_r.win.x0),
    .length  (s_r.win.w),
    .shuffle (s_r.hshuf),
    .reverse (s_r.hmir),
    .addr    (col_now),
    .last    (col_last)
  );

  // Row counter: vertical shuffle and flip
  axis_sequencer #(
    .W (9)
  ) u_row (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clk_en  (clk_en),
    .load    (ax_load),
    .step    (row_step),
    .start   (s_r.win.y0),
    .length  (s_r.win.h),
    .shuffle (s_r.vshuf),
    .reverse (s_r.vflip),
    .addr    (row_now),
    .last    (row_last)
  );

  // Window chosen from mode and programmed corner
  assign win_sel = mode_window(video_mode, x_offset, y_offset);

  // Counter strobes
  assign ax_load  = frame_start;
  assign col_step = (s_r.st == ST_SCAN) && pix_adv && !frame_start;
  assign row_step = col_step && col_last;

  // ----------------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt        = s_r;
    s_nxt.valid  = 1'b0;
    s_nxt.lline  = 1'b0;
    s_nxt.lframe = 1'b0;
    s_nxt.rdata  = rdata_comb;
    if (frame_start) begin
      // Latch placement and options for the whole frame
      s_nxt.st    = ST_SCAN;
      s_nxt.win   = win_sel;
      s_nxt.hshuf = ctrl_a[`BIT_HSHUFFLE];
      s_nxt.hmir  = ctrl_b[`BIT_HMIRROR];
      s_nxt.vshuf = ctrl_b[`BIT_VSHUFFLE];
      s_nxt.vflip = ctrl_b[`BIT_VFLIP];
    end else begin
      unique case (s_r.st)
        ST_IDLE: begin
          // Wait for the next frame
          s_nxt.st = ST_IDLE;
        end
        ST_SCAN: begin
          if (pix_adv) begin
            // Present the current array address
            s_nxt.col    = col_now;
            s_nxt.row    = row_now;
            s_nxt.valid  = 1'b1;
            s_nxt.lline  = col_last;
            s_nxt.lframe = col_last && row_last;
            if (col_last && row_last) begin
              s_nxt.st = ST_IDLE;
            end
          end
        end
        default: begin
          // Illegal one-hot code recovers to idle
          s_nxt.st = ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '{st: ST_IDLE, win: '{x0: `PAL_X0, y0: `PAL_Y0, w: `PAL_W, h: `PAL_H},
               hshuf: 1'b1, hmir: 1'b0, vshuf: 1'b0, vflip: 1'b0,
               col: 9'h000, row: 9'h000, valid: 1'b0, lline: 1'b0,
               lframe: 1'b0, rdata: 8'h00};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------------
  assign col_addr   = s_r.col;
  assign row_addr   = s_r.row;
  assign pix_valid  = s_r.valid;
  assign line_last  = s_r.lline;
  assign frame_last = s_r.lframe;
  assign frame_busy = s_r.st[1];
  assign reg_rdata  = s_r.rdata;

endmodule : pixel_array_readout_addressing

`default_nettype wire

// >>> hdl/readout_consts.svh
`ifndef READOUT_CONSTS_SVH
`define READOUT_CONSTS_SVH

// ----------------------------------------------------------------------
// Serial register offsets
// ----------------------------------------------------------------------
`define REG_CTRL_A        8'h11
`define REG_CTRL_B        8'h16
`define REG_XOFF_HI       8'h58
`define REG_XOFF_LO       8'h59
`define REG_YOFF_HI       8'h5a
`define REG_YOFF_LO       8'h5b

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CTRL_A_RESET      8'h80
`define CTRL_B_RESET      8'h00
`define XOFF_RESET        9'h05d
`define YOFF_RESET        9'h04f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_HSHUFFLE      7
`define BIT_HMIRROR       3
`define BIT_VSHUFFLE      2
`define BIT_VFLIP         4

// ----------------------------------------------------------------------
// Physical array and window geometry
// ----------------------------------------------------------------------
`define ARRAY_COLS        9'h16c
`define ARRAY_ROWS        9'h128
`define NTSC_W            9'h132
`define NTSC_H            9'h0f4
`define PAL_W             9'h164
`define PAL_H             9'h124
`define QCIF_W            9'h0b4
`define QCIF_H            9'h094

// ----------------------------------------------------------------------
// Fixed start coordinates per mode
// ----------------------------------------------------------------------
`define PAL_X0            9'h005
`define PAL_Y0            9'h007
`define NTSC_X0           9'h01d
`define NTSC_Y0           9'h01d
`define QCIF_X0           9'h05d
`define QCIF_Y0           9'h04f

// ----------------------------------------------------------------------
// Pan/tilt start limits
// ----------------------------------------------------------------------
`define PT_X_MIN          9'h001
`define PT_X_MAX          9'h0b9
`define PT_Y_MIN          9'h005
`define PT_Y_MAX          9'h095

`endif

// >>> hdl/readout_pkg.sv
`default_nettype none

package readout_pkg;

  // Video mode selected by the timing logic
  typedef enum logic [2:0] {
    MODE_NTSC    = 3'h0,
    MODE_PAL     = 3'h1,
    MODE_CIF     = 3'h2,
    MODE_PT_QCIF = 3'h3,
    MODE_SS_QCIF = 3'h4
  } video_mode_t;

  // Scan sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SCAN = 2'b10
  } scan_state_t;

  // Window placement: start corner and size
  typedef struct packed {
    logic [8:0] x0;
    logic [8:0] y0;
    logic [8:0] w;
    logic [8:0] h;
  } window_t;

endpackage : readout_pkg

`default_nettype wire

// >>> hdl/axis_sequencer.sv
`include "readout_consts.svh"
`default_nettype none

module axis_sequencer #(
  parameter int W = 9
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // Sequence control
  input  wire logic         load,
  input  wire logic         step,
  input  wire logic [W-1:0] start,
  input  wire logic [W-1:0] length,
  input  wire logic         shuffle,
  input  wire logic         reverse,
  // Current address
  output logic      [W-1:0] addr,
  output logic              last
);

  typedef struct packed {
    logic [W-1:0] idx;  // Position within the sequence
  } axis_state_t;

  axis_state_t s_r;     // Registered state
  axis_state_t s_nxt;   // Next state

  // --------------------------------------------------------------------
  // Sequence position to window offset
  // --------------------------------------------------------------------
  function automatic logic [W-1:0] seq_offset(input logic [W-1:0] idx,
                                              input logic [W-1:0] len,
                                              input logic         shuf,
                                              input logic         rev);
    logic [W-1:0] i;
    logic [W-1:0] half;
    logic [W-1:0] j;
    i    = rev ? W'(len - idx - 1'b1) : idx;
    half = len >> 1;
    j    = W'(i - half);
    if (!shuf) begin
      seq_offset = i;
    end else if (i < half) begin
      seq_offset = {i[W-2:0], 1'b1};
    end else begin
      seq_offset = {j[W-2:0], 1'b0};
    end
  endfunction : seq_offset

  // Address from start plus offset
  assign addr = W'(start + seq_offset(s_r.idx, length, shuffle, reverse));
  assign last = (s_r.idx == W'(length - 1'b1));

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.idx = '0;
    end else if (step) begin
      s_nxt.idx = last ? '0 : W'(s_r.idx + 1'b1);
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

endmodule : axis_sequencer

`default_nettype wire

// >>> hdl/control_regs.sv
`include "readout_consts.svh"
`default_nettype none

module control_regs (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // Serial register access
  input  wire logic       wr_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  // Register contents
  output logic      [7:0] ctrl_a,
  output logic      [7:0] ctrl_b,
  output logic      [8:0] x_offset,
  output logic      [8:0] y_offset
);

  typedef struct packed {
    logic [7:0] a;     // Readout format control A
    logic [7:0] b;     // Readout format control B
    logic [8:0] xoff;  // Pan/tilt column start
    logic [8:0] yoff;  // Pan/tilt row start
  } regs_state_t;

  regs_state_t s_r;    // Registered state
  regs_state_t s_nxt;  // Next state

  assign ctrl_a   = s_r.a;
  assign ctrl_b   = s_r.b;
  assign x_offset = s_r.xoff;
  assign y_offset = s_r.yoff;

  // --------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      unique case (addr)
        `REG_CTRL_A:  s_nxt.a         = wdata;
        `REG_CTRL_B:  s_nxt.b         = wdata;
        `REG_XOFF_HI: s_nxt.xoff[8]   = wdata[0];
        `REG_XOFF_LO: s_nxt.xoff[7:0] = wdata;
        `REG_YOFF_HI: s_nxt.yoff[8]   = wdata[0];
        `REG_YOFF_LO: s_nxt.yoff[7:0] = wdata;
        default:      s_nxt = s_r;                  // Other offsets ignored
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Read mux, unmapped offsets read zero
  // --------------------------------------------------------------------
  always_comb begin
    unique case (addr)
      `REG_CTRL_A:  rdata = s_r.a;
      `REG_CTRL_B:  rdata = s_r.b;
      `REG_XOFF_HI: rdata = {7'h00, s_r.xoff[8]};
      `REG_XOFF_LO: rdata = s_r.xoff[7:0];
      `REG_YOFF_HI: rdata = {7'h00, s_r.yoff[8]};
      `REG_YOFF_LO: rdata = s_r.yoff[7:0];
      default:      rdata = 8'h00;
    endcase
  end

  // State register, shuffle on after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '{a: `CTRL_A_RESET, b: `CTRL_B_RESET,
               xoff: `XOFF_RESET, yoff: `YOFF_RESET};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

endmodule : control_regs

`default_nettype wire

// >>> sim/readout_monitor.sv
`include "readout_consts.svh"
`default_nettype none

module readout_monitor (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       clk_en,
  // Requests
  input wire logic       frame_start,
  input wire logic       pix_adv,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // Answers
  input wire logic [7:0] reg_rdata,
  input wire logic [8:0] col_addr,
  input wire logic [8:0] row_addr,
  input wire logic       pix_valid,
  input wire logic       line_last,
  input wire logic       frame_last,
  input wire logic       frame_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----
  // Stream, register readback and clock enable checks
  // ----
  valid_cause_a: assert property (
    pix_valid && $past(clk_en) |-> $past(pix_adv) && !$past(frame_start))
    else $error("pixel emitted without an advance");
  line_flag_a: assert property (
    line_last |-> pix_valid) else $error("row end flag without pixel");
  frame_end_a: assert property (
    frame_last |-> line_last && pix_valid && !frame_busy)
    else $error("frame end not on a row end");
  busy_end_a: assert property (
    $fell(frame_busy) |-> frame_last) else $error("busy dropped early");
  busy_start_a: assert property (
    frame_start && clk_en |=> frame_busy) else $error("frame did not start");
  idle_quiet_a: assert property (
    clk_en && !frame_busy && !frame_start |=> !pix_valid)
    else $error("pixel emitted while idle");
  col_range_a: assert property (
    pix_valid |-> col_addr >= 9'h001 && col_addr <= `ARRAY_COLS)
    else $error("column outside array");
  row_range_a: assert property (
    pix_valid |-> row_addr >= 9'h005 && row_addr <= 9'h12c)
    else $error("row in black or dark lines");
  ctrl_readback_a: assert property (
    clk_en && reg_wr_en && reg_addr == `REG_CTRL_B ##1
    clk_en && !reg_wr_en && reg_addr == `REG_CTRL_B |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control b readback wrong");
  freeze_hold_a: assert property (
    !clk_en |=> $stable(col_addr) && $stable(row_addr) && $stable(pix_valid) &&
    $stable(frame_busy) && $stable(reg_rdata))
    else $error("state moved while clock enable low");
endmodule : readout_monitor

`default_nettype wire

// >>> sim/video_host_model.sv
`default_nettype none

module video_host_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // Bench control
  input  wire logic        frame_start,
  input  wire logic [15:0] want,
  input  wire logic        stall,
  // Stream handshake
  input  wire logic        frame_busy,
  output logic             pix_adv
);
  logic [15:0] taken_r; // Advances accepted this frame
  // Asks for pixels up to the wanted count, pausing on stall
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      taken_r <= 16'h0000;
      pix_adv <= 1'b0;
    end else if (frame_start) begin
      taken_r <= 16'h0000;
      pix_adv <= 1'b0;
    end else begin
      // An advance counts only on an edge where the block is enabled
      if (pix_adv && frame_busy && clk_en) taken_r <= taken_r + 16'h0001;
      pix_adv <= !stall && (taken_r + 16'(pix_adv && frame_busy && clk_en) < want);
    end
  end
endmodule : video_host_model

`default_nettype wire

// >>> sim/pixel_array_readout_addressing_bench.sv
`include "readout_consts.svh"
`default_nettype none

`define CHK(what, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", what, e, s); end end

module pixel_array_readout_addressing_bench
  import readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [8:0] col;
    logic [8:0] row;
    logic       ll;
    logic       fl;
  } pix_note_t;
  logic        clk_sys;
  logic        reset = 1'b1;
  logic        frame_start = 1'b0;
  video_mode_t video_mode = MODE_CIF;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [8:0]  col_addr, row_addr;
  logic        pix_valid, line_last, frame_last, frame_busy, pix_adv;
  logic        stall = 1'b0;
  logic        clk_en = 1'b1; // Random freezes while a frame runs
  logic        gate = 1'b0;   // Allows freezes
  logic        en_q = 1'b0;   // Clock enable at the previous edge
  logic [15:0] want = 16'h0000;
  logic [31:0] rng = 32'h0000001a;
  pix_note_t   exp_q[$]; // Expected pixels, oldest first
  pix_note_t   note;
  int          err_total = 0;
  int          comparisons = 0;
  int          t;

  pixel_array_readout_addressing u_dut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .video_mode(video_mode),
    .frame_start(frame_start), .pix_adv(pix_adv), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .col_addr(col_addr), .row_addr(row_addr), .pix_valid(pix_valid),
    .line_last(line_last), .frame_last(frame_last), .frame_busy(frame_busy));
  video_host_model u_host (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .frame_start(frame_start), .want(want),
    .stall(stall), .frame_busy(frame_busy), .pix_adv(pix_adv));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  function automatic logic [8:0] seq(input int i, input int w, input logic shuf,
                                     input logic rev);
    int k;
    k = rev ? w - 1 - i : i;
    if (!shuf) return 9'(k);
    return k < w / 2 ? 9'(2 * k + 1) : 9'(2 * (k - w / 2));
  endfunction : seq
  function automatic logic [8:0] clip(input logic [8:0] v, input logic [8:0] lo,
                                      input logic [8:0] hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction : clip
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 `CHK(what, e, reg_rdata)
  endtask : rd_chk
  // Programs one frame, notes its pixels, then waits for them
  task automatic frame(input video_mode_t m, input logic [3:0] opt, input logic [8:0] xo,
                       input logic [8:0] yo, input int rows);
    window_t win;
    int      n, k;
    wr(`REG_CTRL_A, {opt[0], 7'h00});
    wr(`REG_CTRL_B, {3'h0, opt[3], opt[1], opt[2], 2'h0});
    wr(`REG_XOFF_HI, {7'h00, xo[8]});
    wr(`REG_XOFF_LO, xo[7:0]);
    wr(`REG_YOFF_HI, {7'h00, yo[8]});
    wr(`REG_YOFF_LO, yo[7:0]);
    case (m)
      MODE_NTSC:    win = '{`NTSC_X0, `NTSC_Y0, `NTSC_W, `NTSC_H};
      MODE_PT_QCIF: win = '{clip(xo, `PT_X_MIN, `PT_X_MAX),
                            clip(yo, `PT_Y_MIN, `PT_Y_MAX), `QCIF_W, `QCIF_H};
      MODE_SS_QCIF: win = '{`QCIF_X0, `QCIF_Y0, `QCIF_W, `QCIF_H};
      default:      win = '{`PAL_X0, `PAL_Y0, `PAL_W, `PAL_H};
    endcase
    n = rows * win.w;
    for (k = 0; k < n; k++) begin
      exp_q.push_back('{win.x0 + seq(k % win.w, win.w, opt[0], opt[1]),
                        win.y0 + seq(k / win.w, win.h, opt[2], opt[3]),
                        k % win.w == win.w - 1, k == win.w * win.h - 1});
    end
    video_mode <= m;
    frame_start <= 1'b1;
    want <= 16'(n);
    @(posedge clk_sys);
    frame_start <= 1'b0;
    gate <= 1'b1;
    for (k = 0; k < 4 * n + 100 && exp_q.size() != 0; k++) @(posedge clk_sys);
    gate <= 1'b0;
    `CHK("pixels left", 0, exp_q.size())
    exp_q.delete();
  endtask : frame
  task automatic end_of_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // ----
  // Clock, stalls, watchdog
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) stall <= (xs() & 32'h3) == 32'h0;
  // Clock enable drops at random only while pixels are being read
  always @(posedge clk_sys) clk_en <= !gate || (xs() & 32'h7) != 32'h0;
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    end_of_test();
  end
  // Compares each emitted pixel with the oldest note
  always @(posedge clk_sys) begin
    // A pixel is new only if the block was enabled on the edge before
    if (pix_valid === 1'b1 && en_q) begin
      `CHK("pixel pending", 1'b1, exp_q.size() != 0)
      if (exp_q.size() != 0) begin
        note = exp_q.pop_front();
        `CHK("pixel", note, {col_addr, row_addr, line_last, frame_last})
      end
    end
    en_q <= clk_en;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk("ctrl a", `REG_CTRL_A, 8'h80);
    rd_chk("ctrl b", `REG_CTRL_B, 8'h00);
    rd_chk("x hi", `REG_XOFF_HI, 8'h00);
    rd_chk("x lo", `REG_XOFF_LO, 8'h5d);
    rd_chk("y lo", `REG_YOFF_LO, 8'h4f);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(`REG_CTRL_B, 8'h1c);
    rd_chk("ctrl b", `REG_CTRL_B, 8'h1c);
    wr(`REG_YOFF_HI, 8'hff);
    rd_chk("y hi", `REG_YOFF_HI, 8'h01);
    for (t = 0; t < 16; t++) begin
      frame(video_mode_t'(t % 5), t[3:0], 9'(xs()), 9'(xs()), 2);
    end
    frame(MODE_PT_QCIF, 4'h0, 9'h000, 9'h1ff, 2);
    frame(MODE_PT_QCIF, 4'(xs()), 9'h0b9, 9'h095, 148);
    end_of_test();
  end
endmodule : pixel_array_readout_addressing_bench

bind pixel_array_readout_addressing readout_monitor u_mon (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .frame_start(frame_start),
  .pix_adv(pix_adv), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .col_addr(col_addr),
  .row_addr(row_addr), .pix_valid(pix_valid), .line_last(line_last),
  .frame_last(frame_last), .frame_busy(frame_busy));

`default_nettype wire
